/* File: core/vipc_consts.svh */
// Offsets, field positions, reset values and vector constants
`ifndef VIPC_CONSTS_SVH
`define VIPC_CONSTS_SVH
`define VIPC_NSRC 104
`define VIPC_IDX_CTRL1 6'h00
`define VIPC_IDX_CTRL2 6'h01
`define VIPC_IDX_FLAG0 6'h02
`define VIPC_IDX_FLAG6 6'h08
`define VIPC_IDX_EN0 6'h09
`define VIPC_IDX_EN6 6'h0F
`define VIPC_IDX_PRIO0 6'h10
`define VIPC_IDX_PRIO25 6'h29
`define VIPC_IDX_TSTAT 6'h2A
`define VIPC_IDX_STAT 6'h2B
`define VIPC_IDX_CORE 6'h2C
`define VIPC_SKIP_A 14
`define VIPC_SKIP_B 17
`define VIPC_SKIP_C 24
`define VIPC_NEST_BIT 15
`define VIPC_ALT_BIT 15
`define VIPC_TRAP_LSB 1
`define VIPC_LVL_LSB 5
`define VIPC_TOP_BIT 3
`define VIPC_RSVD_BIT 2
`define VIPC_LVL_MAX 3'h7
`define VIPC_RST16 16'h0000
`define VIPC_VEC_BASE 24'h000014
`define VIPC_ALT_OFS 24'h000100
`define VIPC_EXT0 0
`define VIPC_EXT1 20
`define VIPC_EXT2 29
`define VIPC_EXT3 53
`define VIPC_EXT4 54
`endif

/* File: core/vipc_pkg.sv */
// Types shared by the interrupt controller
package vipc_pkg;
    typedef struct packed {
        logic req;
        logic [6:0] vector;
        logic [3:0] level;
        logic [23:0] addr;
    } vipc_irq_s;
    typedef struct packed {
        logic arith;
        logic address;
        logic stack;
        logic osc;
    } vipc_trap_s;
endpackage

/* File: core/vipc_top.sv */
// Vectored priority interrupt controller with APB register access
//
// Functional notes
// [RULE_01] Forty registers: controls, flags, enables, priorities, status; the map here has 45 (0x00-0x2C)
// [RULE_02] Hardware sets flag; only software clears it
// [RULE_03] Disabled source never forwarded to CPU
// [RULE_04] Three-bit priority per source, levels 0-7
// [RULE_05] Latch vector and new level into status
// [RULE_06] New level equals presented source priority
// [RULE_07] Bits allocated in ascending vector order
// [RULE_08] Fixed vector, alternate table 0x100 higher
// [RULE_09] Small-package sources removable by parameter
// [RULE_10] CPU level low bits writable at 7:5
// [RULE_11] Fourth level bit read-only, core bit 3; here a write of zero to bit 3 clears it
// [RULE_12] Fourth bit adds eight to level
// [RULE_13] Level field 111 blocks all user sources
// [RULE_14] Nesting disable makes level bits read-only
// [RULE_15] Control one: nesting disable and trap flags
// [RULE_16] Control two: external edges, alternate table
// [RULE_17] Nesting disable bit 15, resets zero
// [RULE_18] Trap events set flags; software clears
// [RULE_19] Highest priority above level, lowest vector
// [RULE_20] Unimplemented bits read zero; reset zero; here reserved bit 2 of the core register reads one
//
// Local design decisions: the address map and the APB interface to the registers.
`include "vipc_consts.svh"

module vipc_top #(
    parameter logic [`VIPC_NSRC-1:0] SRC_PRESENT = {`VIPC_NSRC{1'b1}}
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [`VIPC_NSRC-1:0] src_req_i,
    input wire logic [4:0] ext_pin_i,
    input wire vipc_pkg::vipc_trap_s trap_i,
    input wire logic irq_ack_i,
    output vipc_pkg::vipc_irq_s irq_o
);

    // ========================================
    // Reset release
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ========================================
    // Storage
    logic [`VIPC_NSRC-1:0] flag;
    logic [`VIPC_NSRC-1:0] en;
    logic [2:0] prio [`VIPC_NSRC];
    logic [`VIPC_NSRC-1:0] impl;
    logic [`VIPC_NSRC-1:0] set;
    logic nest_dis;
    logic [3:0] trap_flag;
    logic alt_sel;
    logic [4:0] ext_pol;
    logic [2:0] cpu_low;
    logic cpu_top;
    logic [3:0] cur_level;
    assign cur_level = {cpu_top, cpu_low}; // [RULE_12]

    // ========================================
    // APB decode
    logic [5:0] idx;
    logic acc_wr;
    assign idx = paddr_i[7:2];
    assign acc_wr = psel_i & penable_i & pready_o & pwrite_i;

    // ========================================
    // External pins: synchronise, then edge detect by polarity
    logic [4:0] ext_s1;
    logic [4:0] ext_s2;
    logic [4:0] ext_d;
    logic [4:0] ext_edge;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1 <= 5'h00;
            ext_s2 <= 5'h00;
            ext_d <= 5'h00;
        end else begin
            ext_s1 <= ext_pin_i;
            ext_s2 <= ext_s1;
            ext_d <= ext_s2;
        end
    end
    // Polarity bit set selects the falling edge
    assign ext_edge = (ext_pol & ext_d & ~ext_s2)
                    | (~ext_pol & ~ext_d & ext_s2); // [RULE_16]

    always_comb begin
        set = src_req_i;
        set[`VIPC_EXT0] = set[`VIPC_EXT0] | ext_edge[0];
        set[`VIPC_EXT1] = set[`VIPC_EXT1] | ext_edge[1];
        set[`VIPC_EXT2] = set[`VIPC_EXT2] | ext_edge[2];
        set[`VIPC_EXT3] = set[`VIPC_EXT3] | ext_edge[3];
        set[`VIPC_EXT4] = set[`VIPC_EXT4] | ext_edge[4];
    end

    // ========================================
    // Per-source flag, enable and priority
    // Source i sits at bit i%16 of word i/16, field i%4 of word i/4
    genvar gi;
    generate
        for (gi = 0; gi < `VIPC_NSRC; gi++) begin : g_src
            localparam int PW = gi / 4;
            localparam logic [5:0] FI = 6'(gi / 16);
            localparam logic [5:0] PI = 6'(PW);
            assign impl[gi] = SRC_PRESENT[gi] && PW != `VIPC_SKIP_A
                && PW != `VIPC_SKIP_B && PW != `VIPC_SKIP_C; // [RULE_09]
            // Set beats a clearing write in the same cycle
            always_ff @(posedge mclk_i or negedge rst_n) begin
                if (!rst_n) begin
                    flag[gi] <= 1'b0;
                end else if (impl[gi]) begin
                    flag[gi] <= set[gi] | ((acc_wr && idx ==
                        `VIPC_IDX_FLAG0 + FI) ? pwdata_i[gi % 16]
                        : flag[gi]); // [RULE_02] [RULE_07]
                end
            end
            always_ff @(posedge mclk_i or negedge rst_n) begin
                if (!rst_n) begin
                    en[gi] <= 1'b0;
                end else if (impl[gi] && acc_wr
                        && idx == `VIPC_IDX_EN0 + FI) begin
                    en[gi] <= pwdata_i[gi % 16]; // [RULE_03] [RULE_07]
                end
            end
            always_ff @(posedge mclk_i or negedge rst_n) begin
                if (!rst_n) begin
                    prio[gi] <= 3'h0;
                end else if (impl[gi] && acc_wr
                        && idx == `VIPC_IDX_PRIO0 + PI) begin
                    prio[gi] <= pwdata_i[4 * (gi % 4) +: 3]; // [RULE_04]
                end
            end
        end
    endgenerate

    // ========================================
    // Global controls and traps
    logic trap_any;
    assign trap_any = |trap_i;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            nest_dis <= 1'b0; // [RULE_17]
            trap_flag <= 4'h0;
        end else begin
            if (acc_wr && idx == `VIPC_IDX_CTRL1) begin
                nest_dis <= pwdata_i[`VIPC_NEST_BIT]; // [RULE_15]
            end
            trap_flag <= trap_i | ((acc_wr && idx == `VIPC_IDX_CTRL1)
                ? pwdata_i[`VIPC_TRAP_LSB +: 4] : trap_flag); // [RULE_18]
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            alt_sel <= 1'b0;
            ext_pol <= 5'h00;
        end else if (acc_wr && idx == `VIPC_IDX_CTRL2) begin
            alt_sel <= pwdata_i[`VIPC_ALT_BIT]; // [RULE_16]
            ext_pol <= pwdata_i[4:0];
        end
    end

    // ========================================
    // CPU level: acceptance raises it, software may rewrite low bits
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_low <= 3'h0;
        end else if (irq_ack_i && irq_o.req) begin
            cpu_low <= irq_o.level[2:0];
        end else if (acc_wr && idx == `VIPC_IDX_STAT && !nest_dis) begin
            cpu_low <= pwdata_i[`VIPC_LVL_LSB +: 3]; // [RULE_10] [RULE_14]
        end
    end
    // Top bit only set by traps; a write can clear but never set it
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_top <= 1'b0;
        end else if (trap_any) begin
            cpu_top <= 1'b1;
        end else if (acc_wr && idx == `VIPC_IDX_CORE
                && !pwdata_i[`VIPC_TOP_BIT]) begin
            cpu_top <= 1'b0; // [RULE_11]
        end
    end

    // ========================================
    // Arbitration: descending scan so equal priority keeps lower vector
    logic pend;
    logic [6:0] best_vec;
    logic [3:0] best_lvl;
    always_comb begin
        pend = 1'b0;
        best_vec = 7'h00;
        best_lvl = 4'h0;
        for (int i = `VIPC_NSRC - 1; i >= 0; i--) begin
            if (flag[i] && en[i] && impl[i] && cpu_low != `VIPC_LVL_MAX
                    && {1'b0, prio[i]} > cur_level
                    && (!pend || {1'b0, prio[i]} >= best_lvl)) begin
                pend = 1'b1; // [RULE_19] [RULE_13] [RULE_03]
                best_vec = 7'(i);
                best_lvl = {1'b0, prio[i]}; // [RULE_06]
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= '0;
        end else begin
            irq_o.req <= pend;
            if (pend) begin
                irq_o.vector <= best_vec; // [RULE_05]
                irq_o.level <= best_lvl;
                irq_o.addr <= `VIPC_VEC_BASE + {16'h0000, best_vec, 1'b0}
                    + (alt_sel ? `VIPC_ALT_OFS : 24'h000000); // [RULE_08]
            end
        end
    end

    // ========================================
    // Read mux; unmapped or misaligned gives an error
    logic [15:0] rd;
    logic rd_ok;
    logic [5:0] sub;
    logic [`VIPC_NSRC+7:0] flag_pad;
    logic [`VIPC_NSRC+7:0] en_pad;
    assign flag_pad = {8'h00, flag};
    assign en_pad = {8'h00, en};
    always_comb begin
        rd = `VIPC_RST16; // [RULE_20]
        rd_ok = paddr_i[1:0] == 2'b00;
        sub = 6'h00;
        if (idx == `VIPC_IDX_CTRL1) begin // [RULE_01]
            rd[`VIPC_NEST_BIT] = nest_dis;
            rd[`VIPC_TRAP_LSB +: 4] = trap_flag;
        end else if (idx == `VIPC_IDX_CTRL2) begin
            rd[`VIPC_ALT_BIT] = alt_sel;
            rd[4:0] = ext_pol;
        end else if (idx <= `VIPC_IDX_FLAG6) begin
            sub = idx - `VIPC_IDX_FLAG0;
            rd = flag_pad[{sub[2:0], 4'h0} +: 16];
        end else if (idx <= `VIPC_IDX_EN6) begin
            sub = idx - `VIPC_IDX_EN0;
            rd = en_pad[{sub[2:0], 4'h0} +: 16];
        end else if (idx <= `VIPC_IDX_PRIO25) begin
            sub = idx - `VIPC_IDX_PRIO0;
            for (int j = 0; j < 4; j++) begin
                rd[4 * j +: 3] = prio[7'({sub[4:0], 2'b00}) + 7'(j)];
            end
        end else if (idx == `VIPC_IDX_TSTAT) begin
            rd = {5'h00, irq_o.level, irq_o.vector};
        end else if (idx == `VIPC_IDX_STAT) begin
            rd[`VIPC_LVL_LSB +: 3] = cpu_low;
        end else if (idx == `VIPC_IDX_CORE) begin
            rd[`VIPC_TOP_BIT] = cpu_top;
            rd[`VIPC_RSVD_BIT] = 1'b1;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Answer registered in setup so every output comes from a flop
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~rd_ok;
            if (psel_i && !penable_i) begin
                prdata_o <= (rd_ok && !pwrite_i) ? {16'h0000, rd}
                    : 32'h00000000;
            end
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    sequence s_lvl_write;
        acc_wr && idx == `VIPC_IDX_STAT && nest_dis && !irq_ack_i;
    endsequence
    sequence s_top_write;
        acc_wr && idx == `VIPC_IDX_CORE && pwdata_i[`VIPC_TOP_BIT]
            && !trap_any;
    endsequence

    a_flag_sticky: assert property (set[3] && impl[3] |=> flag[3]) // [RULE_02]
        else $error("flag not set by request");
    a_flag_hold: assert property (!set[3] && !(acc_wr
        && idx == `VIPC_IDX_FLAG0) |=> flag[3] == $past(flag[3]))
        else $error("flag changed without cause"); // [RULE_02]
    a_level_match: assert property (pend |-> best_lvl
        == {1'b0, prio[best_vec]} && en[best_vec]) // [RULE_06]
        else $error("level differs from source priority");
    a_ipl7_masks: assert property (cpu_low == `VIPC_LVL_MAX |-> !pend
        ##1 !irq_o.req) // [RULE_13]
        else $error("user source taken at level seven");
    a_above_level: assert property (pend |-> best_lvl > cur_level)
        else $error("request not above cpu level"); // [RULE_19]
    a_nest_lock: assert property (s_lvl_write |=> $stable(cpu_low))
        else $error("level written while nesting disabled"); // [RULE_14]
    a_top_ro: assert property (s_top_write |=> cpu_top == $past(cpu_top))
        else $error("top level bit set by software"); // [RULE_11]
    a_vec_addr: assert property (irq_o.req |-> irq_o.addr
        == `VIPC_VEC_BASE + {16'h0000, irq_o.vector, 1'b0}
        + ($past(alt_sel) ? `VIPC_ALT_OFS : 24'h000000))
        else $error("vector address wrong"); // [RULE_08]
    a_skip_zero: assert property (flag[56] == 1'b0 && en[68] == 1'b0)
        else $error("skipped source implemented"); // [RULE_20]

endmodule

/* File: tb/vipc_cpu_model.sv */
// CPU-side model that accepts presented interrupts after a delay
module vipc_cpu_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic take_i,
    input wire logic [3:0] delay_i,
    input wire vipc_pkg::vipc_irq_s irq_i,
    output logic ack_o
);
    logic [3:0] wait_cnt;
    logic live;

    // ======================================================
    // Acknowledge
    // Only a live request is acknowledged, never a stale one
    assign live = take_i && irq_i.req && !ack_o;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (live && wait_cnt == delay_i) begin
            ack_o <= 1'b1;
            wait_cnt <= 4'h0;
        end else if (live) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            ack_o <= 1'b0;
            wait_cnt <= 4'h0;
        end
    end
endmodule

/* File: tb/vectored_interrupt_priority_ctrl_bench.sv */
// Register and interrupt presentation bench for the controller
`include "vipc_consts.svh"

module vectored_interrupt_priority_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic [`VIPC_NSRC-1:0] src = '0;
    logic [4:0] ext = 5'h00;
    vipc_pkg::vipc_trap_s trap = '0;
    logic ack;
    logic take = 1'b0;
    vipc_pkg::vipc_irq_s irq;
    logic [31:0] rv;
    logic re;
    int errors = 0;
    int cmp_count = 0;

    always #25 clk = ~clk;

    vipc_top dut (.mclk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .src_req_i(src), .ext_pin_i(ext), .trap_i(trap),
        .irq_ack_i(ack), .irq_o(irq));

    vipc_cpu_model cpu (.clk_i(clk), .rst_n_i(rst_n), .take_i(take),
        .delay_i(4'h2), .irq_i(irq), .ack_o(ack));

    // ======================================================
    // Tasks
    task automatic finish_test;
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // APB transfer; request held until ready is seen high
    task automatic bus(input logic w, input logic [5:0] i,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= {i, 2'b00};
        pwd <= d;
        @(posedge clk) pen <= 1'b1;
        // Ready and data are taken at the rising edge that ends access
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            $display("wrong value at %0t: no ready", $time);
            finish_test();
        end
        rv = prd;
        re = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        // One idle edge so the next call never re-drives in this step
        @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
    endtask

    task automatic rd(input logic [5:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        cmp(rv, e);
    endtask

    task automatic chk_irq(input logic q, input logic [6:0] v,
                           input logic [3:0] l, input logic [23:0] a);
        vipc_pkg::vipc_irq_s e;
        e = '{q, v, l, a};
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_count++;
        if (irq !== e) begin
            errors++;
            $display("wrong value at %0t: irq %h want %h", $time, irq, e);
        end
        @(posedge clk);
    endtask

    task automatic pulse(input int v);
        src[v] <= 1'b1;
        @(posedge clk);
        src[v] <= 1'b0;
        @(posedge clk);
    endtask

    // ======================================================
    // Sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`VIPC_IDX_CTRL1, 32'h0);
        rd(`VIPC_IDX_CTRL2, 32'h0);
        rd(`VIPC_IDX_CORE, 32'h4);
        rd(`VIPC_IDX_TSTAT, 32'h0);
        wr(`VIPC_IDX_PRIO0 + 6'h0E, 32'hFFFF);
        rd(`VIPC_IDX_PRIO0 + 6'h0E, 32'h0);
        rd(6'h2D, 32'h0);
        cmp({31'h0, re}, 32'h1);
        pulse(3);
        rd(`VIPC_IDX_FLAG0, 32'h8);
        chk_irq(1'b0, 7'h00, 4'h0, 24'h0);
        wr(`VIPC_IDX_PRIO0, 32'h5000);
        rd(`VIPC_IDX_PRIO0, 32'h5000);
        wr(`VIPC_IDX_EN0, 32'h0008);
        chk_irq(1'b1, 7'h03, 4'h5, 24'h00001A);
        rd(`VIPC_IDX_TSTAT, 32'h283);
        wr(`VIPC_IDX_CTRL2, 32'h8000);
        chk_irq(1'b1, 7'h03, 4'h5, 24'h00011A);
        // Equal priority on a higher vector must lose the tie
        wr(`VIPC_IDX_PRIO0 + 6'h01, 32'h5000);
        wr(`VIPC_IDX_PRIO0 + 6'h02, 32'h0006);
        wr(`VIPC_IDX_EN0, 32'h0188);
        pulse(7);
        chk_irq(1'b1, 7'h03, 4'h5, 24'h00011A);
        pulse(8);
        chk_irq(1'b1, 7'h08, 4'h6, 24'h000124);
        wr(`VIPC_IDX_STAT, 32'h00E0);
        chk_irq(1'b0, 7'h08, 4'h6, 24'h000124);
        wr(`VIPC_IDX_STAT, 32'h00A0);
        rd(`VIPC_IDX_STAT, 32'h00A0);
        chk_irq(1'b1, 7'h08, 4'h6, 24'h000124);
        wr(`VIPC_IDX_CTRL1, 32'h8000);
        rd(`VIPC_IDX_CTRL1, 32'h8000);
        wr(`VIPC_IDX_STAT, 32'h0000);
        rd(`VIPC_IDX_STAT, 32'h00A0);
        wr(`VIPC_IDX_CTRL1, 32'h0000);
        take <= 1'b1;
        repeat (6) @(posedge clk);
        take <= 1'b0;
        chk_irq(1'b0, 7'h08, 4'h6, 24'h000124);
        rd(`VIPC_IDX_STAT, 32'h00C0);
        wr(`VIPC_IDX_FLAG0, 32'h0);
        rd(`VIPC_IDX_FLAG0, 32'h0);
        ext[0] <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`VIPC_IDX_FLAG0, 32'h1);
        trap.arith <= 1'b1;
        @(posedge clk);
        trap.arith <= 1'b0;
        @(posedge clk);
        rd(`VIPC_IDX_CTRL1, 32'h10);
        rd(`VIPC_IDX_CORE, 32'hC);
        wr(`VIPC_IDX_PRIO0, 32'h7000);
        pulse(3);
        chk_irq(1'b0, 7'h08, 4'h6, 24'h000124);
        wr(`VIPC_IDX_CORE, 32'h0);
        rd(`VIPC_IDX_CORE, 32'h4);
        chk_irq(1'b1, 7'h03, 4'h7, 24'h00011A);
        wr(`VIPC_IDX_CTRL1, 32'h0);
        rd(`VIPC_IDX_CTRL1, 32'h0);
        finish_test();
    end
endmodule
